// >>> rmc_carrier_gen.sv
`timescale 1ns/100ps
`default_nettype none
// 8-bit carrier counter and carrier level
module rmc_carrier_gen #(
  parameter int CW = 8
) (
  input wire logic clk,
  input wire logic rst,
  rmc_carrier_if.gen cif
);
  logic [CW-1:0] cnt_ff; // carrier counter
  logic carrier_ff; // registered carrier level

  // counter wraps to zero after passing the period value
  always_ff @(posedge clk)
  begin
    if (rst || cif.clear)
    begin
      cnt_ff <= '0;
    end
    else if (cif.run)
    begin
      // cycle ends once the count has passed the period
      if (cnt_ff >= cif.period)
        cnt_ff <= '0;
      else
        cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // high from zero until count passes the high period
  always_ff @(posedge clk)
  begin
    if (rst || cif.clear)
      carrier_ff <= 1'b0;
    else
      carrier_ff <= cif.run && (cnt_ff <= cif.high);
  end

  assign cif.carrier = carrier_ff;
endmodule
`default_nettype wire

// >>> rmc_carrier_if.sv
`timescale 1ns/100ps
`default_nettype none
// carrier generator settings and result
interface rmc_carrier_if;
  logic [7:0] period; // last count of a carrier cycle
  logic [7:0] high; // last count of the high phase
  logic run; // counter advances
  logic clear; // counter forced to zero
  logic carrier; // carrier level
  modport gen (input period, high, run, clear, output carrier);
  modport ctl (output period, high, run, clear, input carrier);
endinterface
`default_nettype wire

// >>> rmc_ir_emitter.sv
`timescale 1ns/100ps
`default_nettype none
// infrared emitter: counts the cycles in which the led is lit
module rmc_ir_emitter (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic drive,
  output logic [15:0] lit_cnt
);
  // lit time since the last clear
  always_ff @(posedge clk)
  begin
    if (rst || clr)
      lit_cnt <= 16'h0000;
    else if (drive)
      lit_cnt <= lit_cnt + 16'h0001;
  end
endmodule
`default_nettype wire

// >>> rmc_pkg.sv
`default_nettype none
// shared constants of the remote carrier modulator
package rmc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DCNT = 8'h04;
  localparam logic [7:0] OFS_ACTIVE_PULSE_LENGTH = 8'h08;
  localparam logic [7:0] OFS_DATA_CYCLE_LENGTH = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_IEN = 8'h14;
  localparam logic [7:0] OFS_CARR = 8'h18;
  localparam logic [7:0] OFS_MCTL = 8'h1c;
  // control register fields
  localparam int CTL_UNIT_EN = 0;
  localparam int CTL_SW_RST = 1;
  localparam int CTL_ONE_SHOT = 2;
  localparam int CTL_BUF_EN = 3;
  localparam int CTL_DATA_INV = 4;
  localparam int CTL_RUN = 8;
  localparam int CTL_PRESET = 9;
  // status and flag fields
  localparam int FLG_AP = 0;
  localparam int FLG_DB = 1;
  localparam int STS_AP_BSY = 8;
  localparam int STS_DB_BSY = 9;
  localparam int STS_RUNNING = 10;
  // carrier waveform fields
  localparam int CAR_PER_LSB = 0;
  localparam int CAR_HIGH_LSB = 8;
  // modulation control fields
  localparam int MCT_MOD_EN = 0;
  localparam int MCT_OUT_INV = 8;
  // reset values
  localparam logic [15:0] RST_LEN = 16'h0000;
  localparam logic [7:0] RST_CAR = 8'h00;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
endpackage
`default_nettype wire

// >>> rmc_top.sv
// Behaviour
// - running bit shows data counter counting
// - data length busy until buffer transfer
// - data length writes ignored while busy
// - pulse length busy until buffer transfer
// - pulse length writes ignored while busy
// - flags set on cause, write-one clears
// - bit1 data compare, bit0 pulse compare
// - software reset clears both flags
// - enable bits gate each interrupt
// - carrier high from zero to high period
// - carrier cycle ends past period, restarts
// - output polarity bit inverts final output
// - modulation enable selects carrier modulation
// - data active from zero past pulse length
// - data cycle ends past data length
// - one-shot stops and clears run bit
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module rmc_top #(
  parameter int AW = 8, // apb address width
  parameter int LW = 16 // data counter width
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic REMOTE_OUTPUT,
  output logic IRQ
);
  // control register state
  logic unit_enable_ff; // unit enable
  logic one_shot_select_ff; // one-shot mode
  logic buf_enable_ff; // compare buffers on
  logic data_signal_invert_ff; // data signal inversion
  logic counter_run_ff; // counter run control
  // lengths: software-side buffers and active compare values
  logic [LW-1:0] active_pulse_length_buf_ff;
  logic [LW-1:0] data_cycle_length_buf_ff;
  logic [LW-1:0] active_pulse_length_act_ff;
  logic [LW-1:0] data_cycle_length_act_ff;
  logic pulse_length_busy_ff;
  logic data_length_busy_ff;
  // data counter
  logic [LW-1:0] dcnt_ff;
  // flags and enables
  logic data_compare_flag_ff;
  logic pulse_compare_flag_ff;
  logic data_compare_enable_ff;
  logic pulse_compare_enable_ff;
  // carrier settings and output control
  logic [7:0] carrier_high_period_ff;
  logic [7:0] carrier_period_ff;
  logic modulation_enable_ff;
  logic output_polarity_invert_ff;
  logic remote_output_ff;
  logic [31:0] prdata_ff;

  // bus decode
  logic wr_acc; // write access phase
  logic rd_setup; // read setup phase
  logic mapped; // address hits a register
  logic wr_ctrl, wr_active_pulse_length, wr_data_cycle_length;
  logic wr_flags, wr_ien, wr_carr, wr_mctl;
  logic sw_rst; // software reset pulse
  logic cnt_clr; // counter reset pulse
  logic run_en; // counter advances
  logic db_match; // data length compare
  logic ap_match; // pulse length compare
  logic data_sig; // data signal level
  logic mod_out; // modulated, before polarity
  logic [31:0] rd_mux; // read data select

  rmc_carrier_if cif ();

  // address decode on the register map
  always_comb
  begin
    case (PADDR)
      rmc_pkg::OFS_CTRL, rmc_pkg::OFS_DCNT,
      rmc_pkg::OFS_ACTIVE_PULSE_LENGTH, rmc_pkg::OFS_DATA_CYCLE_LENGTH,
      rmc_pkg::OFS_FLAGS, rmc_pkg::OFS_IEN,
      rmc_pkg::OFS_CARR, rmc_pkg::OFS_MCTL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // writes take effect at the access edge only
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign wr_ctrl = wr_acc && (PADDR == rmc_pkg::OFS_CTRL);
  assign wr_active_pulse_length = wr_acc && (PADDR == rmc_pkg::OFS_ACTIVE_PULSE_LENGTH);
  assign wr_data_cycle_length = wr_acc && (PADDR == rmc_pkg::OFS_DATA_CYCLE_LENGTH);
  assign wr_flags = wr_acc && (PADDR == rmc_pkg::OFS_FLAGS);
  assign wr_ien = wr_acc && (PADDR == rmc_pkg::OFS_IEN);
  assign wr_carr = wr_acc && (PADDR == rmc_pkg::OFS_CARR);
  assign wr_mctl = wr_acc && (PADDR == rmc_pkg::OFS_MCTL);

  // zero wait states; unmapped addresses answer with an error
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // one-cycle reset strobes from the control register
  assign sw_rst = wr_ctrl && PWDATA[rmc_pkg::CTL_SW_RST];
  assign cnt_clr = sw_rst
    || (wr_ctrl && PWDATA[rmc_pkg::CTL_PRESET] && unit_enable_ff);

  // counter runs only with the unit enabled
  assign run_en = unit_enable_ff && counter_run_ff;
  assign db_match = run_en && (dcnt_ff == data_cycle_length_act_ff);
  assign ap_match = run_en && (dcnt_ff == active_pulse_length_act_ff);

  // static control bits
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      unit_enable_ff <= 1'b0;
      one_shot_select_ff <= 1'b0;
      buf_enable_ff <= 1'b0;
      data_signal_invert_ff <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      unit_enable_ff <= PWDATA[rmc_pkg::CTL_UNIT_EN];
      one_shot_select_ff <= PWDATA[rmc_pkg::CTL_ONE_SHOT];
      buf_enable_ff <= PWDATA[rmc_pkg::CTL_BUF_EN];
      data_signal_invert_ff <= PWDATA[rmc_pkg::CTL_DATA_INV];
    end
  end

  // run control: software start/stop, self-clear in one-shot
  always_ff @(posedge SYS_CLK)
  begin
    if (RST || sw_rst)
      counter_run_ff <= 1'b0;
    else if (db_match && one_shot_select_ff)
      counter_run_ff <= 1'b0;
    else if (wr_ctrl)
      counter_run_ff <= PWDATA[rmc_pkg::CTL_RUN]
        && PWDATA[rmc_pkg::CTL_UNIT_EN];
  end

  // data counter: 0 up to data length, then wraps
  always_ff @(posedge SYS_CLK)
  begin
    if (RST || cnt_clr)
      dcnt_ff <= '0;
    else if (db_match)
      dcnt_ff <= '0; // cycle ends past data length
    else if (run_en)
      dcnt_ff <= dcnt_ff + 1'b1;
  end

  // pulse length: direct or buffered, busy blocks writes
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      active_pulse_length_buf_ff <= rmc_pkg::RST_LEN;
      active_pulse_length_act_ff <= rmc_pkg::RST_LEN;
      pulse_length_busy_ff <= 1'b0;
    end
    else if (pulse_length_busy_ff)
    begin
      // writes ignored; load at end of data cycle
      if (db_match)
      begin
        active_pulse_length_act_ff <= active_pulse_length_buf_ff;
        pulse_length_busy_ff <= 1'b0;
      end
    end
    else if (wr_active_pulse_length && unit_enable_ff)
    begin
      active_pulse_length_buf_ff <= PWDATA[LW-1:0];
      if (buf_enable_ff)
        pulse_length_busy_ff <= 1'b1;
      else
        active_pulse_length_act_ff <= PWDATA[LW-1:0];
    end
  end

  // data length: direct or buffered, busy blocks writes
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      data_cycle_length_buf_ff <= rmc_pkg::RST_LEN;
      data_cycle_length_act_ff <= rmc_pkg::RST_LEN;
      data_length_busy_ff <= 1'b0;
    end
    else if (data_length_busy_ff)
    begin
      // writes ignored; load at end of data cycle
      if (db_match)
      begin
        data_cycle_length_act_ff <= data_cycle_length_buf_ff;
        data_length_busy_ff <= 1'b0;
      end
    end
    else if (wr_data_cycle_length && unit_enable_ff)
    begin
      data_cycle_length_buf_ff <= PWDATA[LW-1:0];
      if (buf_enable_ff)
        data_length_busy_ff <= 1'b1;
      else
        data_cycle_length_act_ff <= PWDATA[LW-1:0];
    end
  end

  // compare flags: set wins over a write-one clear
  always_ff @(posedge SYS_CLK)
  begin
    if (RST || sw_rst)
    begin
      data_compare_flag_ff <= 1'b0;
      pulse_compare_flag_ff <= 1'b0;
    end
    else
    begin
      // bit 1 data compare, bit 0 pulse compare
      data_compare_flag_ff <= db_match || (data_compare_flag_ff
        && !(wr_flags && PWDATA[rmc_pkg::FLG_DB]));
      pulse_compare_flag_ff <= ap_match || (pulse_compare_flag_ff
        && !(wr_flags && PWDATA[rmc_pkg::FLG_AP]));
    end
  end

  // interrupt enables
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      data_compare_enable_ff <= 1'b0;
      pulse_compare_enable_ff <= 1'b0;
    end
    else if (wr_ien)
    begin
      data_compare_enable_ff <= PWDATA[rmc_pkg::FLG_DB];
      pulse_compare_enable_ff <= PWDATA[rmc_pkg::FLG_AP];
    end
  end

  // request while any enabled flag is set
  assign IRQ = (data_compare_flag_ff && data_compare_enable_ff)
    || (pulse_compare_flag_ff && pulse_compare_enable_ff);

  // carrier waveform settings
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      carrier_high_period_ff <= rmc_pkg::RST_CAR;
      carrier_period_ff <= rmc_pkg::RST_CAR;
    end
    else if (wr_carr)
    begin
      carrier_high_period_ff <= PWDATA[rmc_pkg::CAR_HIGH_LSB +: 8];
      carrier_period_ff <= PWDATA[rmc_pkg::CAR_PER_LSB +: 8];
    end
  end

  // modulation control settings
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      modulation_enable_ff <= 1'b0;
      output_polarity_invert_ff <= 1'b0;
    end
    else if (wr_mctl)
    begin
      modulation_enable_ff <= PWDATA[rmc_pkg::MCT_MOD_EN];
      output_polarity_invert_ff <= PWDATA[rmc_pkg::MCT_OUT_INV];
    end
  end

  // carrier counter runs with the data counter
  assign cif.period = carrier_period_ff;
  assign cif.high = carrier_high_period_ff;
  assign cif.run = run_en;
  assign cif.clear = cnt_clr || !run_en;

  rmc_carrier_gen u_carrier (
    .clk (SYS_CLK),
    .rst (RST),
    .cif (cif.gen)
  );

  // data signal active from zero until past pulse length
  assign data_sig = (run_en && (dcnt_ff <= active_pulse_length_act_ff))
    ^ data_signal_invert_ff;

  // modulate with carrier or pass data alone
  assign mod_out = modulation_enable_ff
    ? (data_sig && cif.carrier) : data_sig;

  // final polarity stage, registered onto the pin
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      remote_output_ff <= 1'b0;
    else
      remote_output_ff <= mod_out ^ output_polarity_invert_ff;
  end

  assign REMOTE_OUTPUT = remote_output_ff;

  // read data select
  always_comb
  begin
    rd_mux = rmc_pkg::RST_RDATA;
    case (PADDR)
      rmc_pkg::OFS_CTRL:
      begin
        rd_mux[rmc_pkg::CTL_UNIT_EN] = unit_enable_ff;
        rd_mux[rmc_pkg::CTL_ONE_SHOT] = one_shot_select_ff;
        rd_mux[rmc_pkg::CTL_BUF_EN] = buf_enable_ff;
        rd_mux[rmc_pkg::CTL_DATA_INV] = data_signal_invert_ff;
        rd_mux[rmc_pkg::CTL_RUN] = counter_run_ff;
      end
      rmc_pkg::OFS_DCNT: rd_mux[LW-1:0] = dcnt_ff;
      rmc_pkg::OFS_ACTIVE_PULSE_LENGTH: rd_mux[LW-1:0] = active_pulse_length_buf_ff;
      rmc_pkg::OFS_DATA_CYCLE_LENGTH: rd_mux[LW-1:0] = data_cycle_length_buf_ff;
      rmc_pkg::OFS_FLAGS:
      begin
        rd_mux[rmc_pkg::STS_RUNNING] = run_en;
        rd_mux[rmc_pkg::STS_DB_BSY] = data_length_busy_ff;
        rd_mux[rmc_pkg::STS_AP_BSY] = pulse_length_busy_ff;
        rd_mux[rmc_pkg::FLG_DB] = data_compare_flag_ff;
        rd_mux[rmc_pkg::FLG_AP] = pulse_compare_flag_ff;
      end
      rmc_pkg::OFS_IEN:
      begin
        rd_mux[rmc_pkg::FLG_DB] = data_compare_enable_ff;
        rd_mux[rmc_pkg::FLG_AP] = pulse_compare_enable_ff;
      end
      rmc_pkg::OFS_CARR:
      begin
        rd_mux[rmc_pkg::CAR_HIGH_LSB +: 8] = carrier_high_period_ff;
        rd_mux[rmc_pkg::CAR_PER_LSB +: 8] = carrier_period_ff;
      end
      rmc_pkg::OFS_MCTL:
      begin
        rd_mux[rmc_pkg::MCT_MOD_EN] = modulation_enable_ff;
        rd_mux[rmc_pkg::MCT_OUT_INV] = output_polarity_invert_ff;
      end
      default: rd_mux = rmc_pkg::RST_RDATA;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      prdata_ff <= rmc_pkg::RST_RDATA;
    else if (rd_setup)
      prdata_ff <= rd_mux;
  end

  assign PRDATA = prdata_ff;
endmodule
`default_nettype wire

// >>> rmc_top_properties.sv
`timescale 1ns/100ps
`default_nettype none
// port-level checks of the modulator
module rmc_top_properties #(
  parameter int AW = 8,
  parameter int LW = 16
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic REMOTE_OUTPUT,
  input wire logic IRQ
);
  wire logic acc = PSEL && PENABLE; // access phase
  wire logic wr = acc && PWRITE; // write takes effect
  wire logic rd = acc && !PWRITE; // read data valid
  wire logic [7:0] adr = 8'(PADDR); // byte address
  logic [1:0] ien_ff; // mirror of the enables
  logic [15:0] car_ff; // mirror of the carrier word
  logic [1:0] mct_ff; // mirror of invert and modulation enable
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // mirrors follow completed writes
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      ien_ff <= 2'h0;
      car_ff <= 16'h0000;
      mct_ff <= 2'h0;
    end
    else if (wr)
    begin
      if (adr == rmc_pkg::OFS_IEN)
        ien_ff <= PWDATA[1:0];
      if (adr == rmc_pkg::OFS_CARR)
        car_ff <= PWDATA[15:0];
      if (adr == rmc_pkg::OFS_MCTL)
        mct_ff <= {PWDATA[8], PWDATA[0]};
    end
  end
  property p_reset_quiet;
    $fell(RST) |-> !IRQ && !REMOTE_OUTPUT && PRDATA == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  property p_irq_masked;
    wr && adr == rmc_pkg::OFS_IEN && PWDATA[1:0] == 2'h0 |=> !IRQ [*2];
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq after masking");
  property p_irq_needs_en;
    ien_ff == 2'h0 |-> !IRQ;
  endproperty
  a_irq_needs_en: assert property (p_irq_needs_en) else $error("irq with no enable");
  property p_flags_rsvd;
    rd && adr == rmc_pkg::OFS_FLAGS |-> PRDATA[31:11] == '0 && PRDATA[7:2] == '0;
  endproperty
  a_flags_rsvd: assert property (p_flags_rsvd) else $error("reserved flag bits set");
  property p_ien_back;
    rd && adr == rmc_pkg::OFS_IEN |-> PRDATA[31:2] == '0 && PRDATA[1:0] == ien_ff;
  endproperty
  a_ien_back: assert property (p_ien_back) else $error("enable readback wrong");
  property p_carr_back;
    rd && adr == rmc_pkg::OFS_CARR |-> PRDATA[31:16] == '0 && PRDATA[15:0] == car_ff;
  endproperty
  a_carr_back: assert property (p_carr_back) else $error("carrier readback wrong");
  property p_mctl_back;
    rd && adr == rmc_pkg::OFS_MCTL |-> {PRDATA[8], PRDATA[0]} == mct_ff && PRDATA[31:9] == '0
      && PRDATA[7:1] == '0;
  endproperty
  a_mctl_back: assert property (p_mctl_back) else $error("modulation readback wrong");
  property p_len_no_err;
    acc && (adr == rmc_pkg::OFS_ACTIVE_PULSE_LENGTH || adr == rmc_pkg::OFS_DATA_CYCLE_LENGTH) |-> !PSLVERR;
  endproperty
  a_len_no_err: assert property (p_len_no_err) else $error("length access errored");
  // every access phase completes at once, so flag reads and clears never stall
  property p_zero_wait;
    acc |-> PREADY;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("access phase not ready");
  // main scenarios
  c_ien_wr: cover property (wr && adr == rmc_pkg::OFS_IEN);
  c_irq: cover property ($rose(IRQ));
  c_busy: cover property (rd && adr == rmc_pkg::OFS_FLAGS && PRDATA[rmc_pkg::STS_DB_BSY]);
endmodule
bind rmc_top rmc_top_properties #(.AW(AW), .LW(LW)) chk_u (.SYS_CLK, .RST, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .REMOTE_OUTPUT, .IRQ);
`default_nettype wire

// >>> test_remote_carrier_modulator_regs.sv
`timescale 1ns/100ps
`default_nettype none
module test_remote_carrier_modulator_regs;
  logic SYS_CLK = 1'b0; // 50 ns clock
  logic RST = 1'b1; // sync reset
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic clr = 1'b0; // restarts the lit count
  logic [31:0] rd; // last read data
  logic err; // last error response
  wire logic [31:0] PRDATA;
  wire logic PREADY;
  wire logic PSLVERR;
  wire logic REMOTE_OUTPUT;
  wire logic IRQ;
  wire logic [15:0] lit; // lit cycles seen by the emitter
  int failures = 0;
  int total_checks = 0;
  logic [7:0] regs [8] = '{rmc_pkg::OFS_CTRL, rmc_pkg::OFS_DCNT, rmc_pkg::OFS_ACTIVE_PULSE_LENGTH,
    rmc_pkg::OFS_DATA_CYCLE_LENGTH, rmc_pkg::OFS_FLAGS, rmc_pkg::OFS_IEN, rmc_pkg::OFS_CARR,
    rmc_pkg::OFS_MCTL};
  // clock
  always #25 SYS_CLK = ~SYS_CLK;
  rmc_top dut_u (.SYS_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .REMOTE_OUTPUT, .IRQ);
  rmc_ir_emitter emit_u (.clk(SYS_CLK), .rst(RST), .clr, .drive(REMOTE_OUTPUT), .lit_cnt(lit));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, then access until ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {16'h0000, d};
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    xfer(1'b0, a, 16'h0000);
    chk(rd & {16'hFFFF, m}, {16'h0000, e});
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    rdm(a, 16'hFFFF, e);
  endtask
  task automatic irqchk(input logic e);
    @(posedge SYS_CLK);
    chk(32'(IRQ), 32'(e));
  endtask
  // lit cycles of the emitter over 40 clocks
  task automatic lit_over(input logic [15:0] e);
    @(posedge SYS_CLK);
    clr <= 1'b1;
    @(posedge SYS_CLK);
    clr <= 1'b0;
    repeat (40) @(posedge SYS_CLK);
    #1;
    chk(32'(lit), 32'(e));
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, about four times the expected run
  initial
  begin
    repeat (2000) @(posedge SYS_CLK);
    failures++;
    give_verdict;
  end
  // test sequence
  initial
  begin
    repeat (4) @(posedge SYS_CLK);
    RST <= 1'b0;
    foreach (regs[i]) rdchk(regs[i], 16'h0000);
    xfer(1'b0, 8'h20, 16'h0000);
    chk(rd, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    $display("reset test done");
    wr(rmc_pkg::OFS_IEN, 16'hFFFF);
    rdchk(rmc_pkg::OFS_IEN, 16'h0003);
    wr(rmc_pkg::OFS_CARR, 16'h0103);
    rdchk(rmc_pkg::OFS_CARR, 16'h0103);
    wr(rmc_pkg::OFS_MCTL, 16'hFFFF);
    rdchk(rmc_pkg::OFS_MCTL, 16'h0101);
    $display("register test done");
    wr(rmc_pkg::OFS_CTRL, 16'h0001);
    wr(rmc_pkg::OFS_DATA_CYCLE_LENGTH, 16'h0009);
    wr(rmc_pkg::OFS_ACTIVE_PULSE_LENGTH, 16'h0009);
    wr(rmc_pkg::OFS_MCTL, 16'h0001);
    wr(rmc_pkg::OFS_CTRL, 16'h0101);
    lit_over(16'h0014);
    wr(rmc_pkg::OFS_MCTL, 16'h0000);
    lit_over(16'h0028);
    wr(rmc_pkg::OFS_MCTL, 16'h0100);
    lit_over(16'h0000);
    wr(rmc_pkg::OFS_MCTL, 16'h0000);
    wr(rmc_pkg::OFS_ACTIVE_PULSE_LENGTH, 16'h0004);
    lit_over(16'h0014);
    irqchk(1'b1);
    rdchk(rmc_pkg::OFS_FLAGS, 16'h0403);
    $display("waveform test done");
    wr(rmc_pkg::OFS_CTRL, 16'h0001);
    rdchk(rmc_pkg::OFS_FLAGS, 16'h0003);
    wr(rmc_pkg::OFS_IEN, 16'h0000);
    irqchk(1'b0);
    wr(rmc_pkg::OFS_IEN, 16'h0002);
    irqchk(1'b1);
    wr(rmc_pkg::OFS_FLAGS, 16'h0002);
    rdchk(rmc_pkg::OFS_FLAGS, 16'h0001);
    irqchk(1'b0);
    wr(rmc_pkg::OFS_FLAGS, 16'h0000);
    rdchk(rmc_pkg::OFS_FLAGS, 16'h0001);
    wr(rmc_pkg::OFS_CTRL, 16'h0003);
    rdchk(rmc_pkg::OFS_FLAGS, 16'h0000);
    $display("flag test done");
    wr(rmc_pkg::OFS_DATA_CYCLE_LENGTH, 16'h0028);
    wr(rmc_pkg::OFS_CTRL, 16'h010D);
    wr(rmc_pkg::OFS_DATA_CYCLE_LENGTH, 16'h0032);
    wr(rmc_pkg::OFS_ACTIVE_PULSE_LENGTH, 16'h0014);
    rdm(rmc_pkg::OFS_FLAGS, 16'h0700, 16'h0700);
    wr(rmc_pkg::OFS_DATA_CYCLE_LENGTH, 16'h003C);
    wr(rmc_pkg::OFS_ACTIVE_PULSE_LENGTH, 16'h001E);
    rdchk(rmc_pkg::OFS_DATA_CYCLE_LENGTH, 16'h0032);
    rdchk(rmc_pkg::OFS_ACTIVE_PULSE_LENGTH, 16'h0014);
    repeat (60) @(posedge SYS_CLK);
    rdm(rmc_pkg::OFS_FLAGS, 16'h0702, 16'h0002);
    rdchk(rmc_pkg::OFS_CTRL, 16'h000D);
    $display("one-shot test done");
    wr(rmc_pkg::OFS_CTRL, 16'h0003);
    wr(rmc_pkg::OFS_CTRL, 16'h0101);
    rdchk(rmc_pkg::OFS_DCNT, 16'h0001);
    wr(rmc_pkg::OFS_CTRL, 16'h0301);
    rdchk(rmc_pkg::OFS_DCNT, 16'h0001);
    wr(rmc_pkg::OFS_CTRL, 16'h0003);
    wr(rmc_pkg::OFS_DATA_CYCLE_LENGTH, 16'h0009);
    wr(rmc_pkg::OFS_ACTIVE_PULSE_LENGTH, 16'h0002);
    wr(rmc_pkg::OFS_CARR, 16'h0000);
    wr(rmc_pkg::OFS_MCTL, 16'h0001);
    wr(rmc_pkg::OFS_CTRL, 16'h0111);
    lit_over(16'h001C);
    wr(rmc_pkg::OFS_CTRL, 16'h0001);
    wr(rmc_pkg::OFS_IEN, 16'h0001);
    irqchk(1'b1);
    wr(rmc_pkg::OFS_FLAGS, 16'h0001);
    rdm(rmc_pkg::OFS_FLAGS, 16'h0003, 16'h0002);
    irqchk(1'b0);
    $display("counter test done");
    give_verdict;
  end
endmodule
`default_nettype wire
